// ---- logic/sat_map.svh ----
// Address map, field positions and reset values of the segment address translator
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH
`define SAT_SEG_W        7
`define SAT_OFS_W        16
`define SAT_NUM_SEGS     64
`define SAT_IDX_W        6
`define SAT_PHYS_W       24
`define SAT_LIMIT_W      8
`define SAT_ATTR_W       5
`define SAT_ATTR_RO      0
`define SAT_ATTR_SYS     1
`define SAT_ATTR_INV     2
`define SAT_ATTR_EXE     3
`define SAT_ATTR_CPU     4
`define SAT_ZERO_BASE    24'h000000
`define SAT_ZERO_LIMIT   8'h00
`define SAT_ZERO_ATTR    5'h00
`endif

// ---- logic/sat_pkg.sv ----
// Types shared by the segment address translator modules
`include "sat_map.svh"
package sat_pkg;
  typedef logic [`SAT_PHYS_W-1:0]  sat_base_t;
  typedef logic [`SAT_LIMIT_W-1:0] sat_limit_t;
  typedef logic [`SAT_ATTR_W-1:0]  sat_attr_t;
endpackage

// ---- logic/sat_check.sv ----
// Access check of one translated access against its segment descriptor
`timescale 1ns/1ps
`include "sat_map.svh"
module sat_check
  import sat_pkg::*;
(
  input  wire logic [`SAT_OFS_W-1:0] ofs,
  input  wire sat_limit_t            limit,
  input  wire sat_attr_t             attr,
  input  wire logic                  wr,
  input  wire logic                  fetch,
  input  wire logic                  sys_mode,
  input  wire logic                  dma,
  output logic                       size_err,
  output logic                       attr_err
);
  // ----------------------------------------------------------------
  // Size check: limit counts 256-byte blocks less one
  // ----------------------------------------------------------------
  assign size_err = ofs[`SAT_OFS_W-1:`SAT_LIMIT_W] > limit; // RULE_04
  // ----------------------------------------------------------------
  // Attribute check
  // ----------------------------------------------------------------
  assign attr_err = (attr[`SAT_ATTR_RO] & wr)            // RULE_09
                  | (attr[`SAT_ATTR_EXE] & ~fetch)
                  | attr[`SAT_ATTR_INV]
                  | (attr[`SAT_ATTR_SYS] & ~sys_mode)
                  | (attr[`SAT_ATTR_CPU] & dma);
endmodule // sat_check

// ---- logic/sat_top.sv ----
// Segment address translator: translation, protection and history
// Overview of operation
// RULE_01: The bus master presents a 7-bit segment number with a 16-bit offset.
// RULE_02: The segment number selects one of 64 table entries.
// RULE_03: The physical address is the segment base plus the offset.
// RULE_04: Each segment has its own size limit from 256 bytes to 64K bytes.
// RULE_05: An offset beyond the segment size raises a trap and blocks the write.
// RULE_06: Each segment holds read-only, system-only, invalid, execute-only and CPU-only attributes.
// RULE_07: An access forbidden by the attributes raises a trap and blocks the write.
// RULE_08: Each segment keeps referenced and changed history flags.
// RULE_09: Write to read-only, non-fetch to execute-only, any to invalid, normal to system-only, DMA to CPU-only are violations.
// RULE_10: Permitted accesses set referenced, permitted writes set changed, suppressed ones touch neither.
`timescale 1ns/1ps
`include "sat_map.svh"
module sat_top
  import sat_pkg::*;
#(
  parameter int NUM_SEGS = `SAT_NUM_SEGS
)(
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   acc_valid,
  input  wire logic [`SAT_SEG_W-1:0]  acc_seg,
  input  wire logic [`SAT_OFS_W-1:0]  acc_ofs,
  input  wire logic                   acc_wr,
  input  wire logic                   acc_fetch,
  input  wire logic                   acc_sys,
  input  wire logic                   acc_dma,
  input  wire logic                   tbl_we,
  input  wire logic [`SAT_IDX_W-1:0]  tbl_idx,
  input  wire sat_base_t              tbl_base,
  input  wire sat_limit_t             tbl_limit,
  input  wire sat_attr_t              tbl_attr,
  input  wire logic                   hist_clr,
  output logic                        out_valid,
  output sat_base_t                   phys_addr,
  output logic                        mem_wr_en,
  output logic                        trap,
  output logic                        trap_size,
  output logic                        trap_attr,
  output logic [NUM_SEGS-1:0]         seg_ref,
  output logic [NUM_SEGS-1:0]         seg_chg
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sat_base_t [NUM_SEGS-1:0]  base;
    sat_limit_t [NUM_SEGS-1:0] limit;
    sat_attr_t [NUM_SEGS-1:0]  attr;
    logic [NUM_SEGS-1:0]       ref_f;
    logic [NUM_SEGS-1:0]       chg_f;
    logic                      vld;
    sat_base_t                 pa;
    logic                      wen;
    logic                      tsz;
    logic                      tat;
  } sat_state_s;

  sat_state_s            st_q;
  sat_state_s            st_d;
  logic [`SAT_IDX_W-1:0] sel;
  logic                  size_err;
  logic                  attr_err;
  sat_base_t             sel_base;
  sat_limit_t            sel_limit;
  sat_attr_t             sel_attr;
  logic                  acc_ok;
  logic                  wr_ok;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Access passes both the size and the attribute check
  function automatic logic fn_permit(
    input logic valid,
    input logic sz_bad,
    input logic at_bad
  );
    return valid & ~sz_bad & ~at_bad;
  endfunction

  // Segment base plus zero-extended offset
  function automatic sat_base_t fn_phys(
    input sat_base_t             base,
    input logic [`SAT_OFS_W-1:0] ofs
  );
    return base + {{(`SAT_PHYS_W-`SAT_OFS_W){1'b0}}, ofs};
  endfunction

  // Set one history flag and keep the others
  function automatic logic [NUM_SEGS-1:0] fn_mark(
    input logic [NUM_SEGS-1:0]   flags,
    input logic [`SAT_IDX_W-1:0] idx,
    input logic                  set
  );
    logic [NUM_SEGS-1:0] res;
    res = flags;
    if (set) begin
      res[idx] = 1'b1;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  // Low six bits of the segment number index the table
  assign sel       = acc_seg[`SAT_IDX_W-1:0]; // RULE_01 RULE_02
  assign sel_base  = st_q.base[sel];          // RULE_02
  assign sel_limit = st_q.limit[sel];         // RULE_04
  assign sel_attr  = st_q.attr[sel];          // RULE_06

  sat_check u_check (
    .ofs      (acc_ofs),
    .limit    (sel_limit),
    .attr     (sel_attr),
    .wr       (acc_wr),
    .fetch    (acc_fetch),
    .sys_mode (acc_sys),
    .dma      (acc_dma),
    .size_err (size_err),
    .attr_err (attr_err)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // ----------------------------------------------------------------
  // Access decision
  // ----------------------------------------------------------------
  assign acc_ok = fn_permit(acc_valid, size_err, attr_err); // RULE_05 RULE_07
  assign wr_ok  = acc_ok & acc_wr;                          // RULE_05 RULE_07

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    st_d.vld = acc_valid;
    st_d.tsz = acc_valid & size_err; // RULE_05
    st_d.tat = acc_valid & attr_err; // RULE_07
    st_d.wen = wr_ok;                // RULE_05 RULE_07
    if (acc_valid) begin
      st_d.pa = fn_phys(sel_base, acc_ofs); // RULE_03
    end
    // Clear first so that a set in the same cycle wins
    if (hist_clr) begin
      st_d.ref_f = '0;
      st_d.chg_f = '0;
    end
    st_d.ref_f = fn_mark(st_d.ref_f, sel, acc_ok); // RULE_08 RULE_10
    st_d.chg_f = fn_mark(st_d.chg_f, sel, wr_ok);  // RULE_08 RULE_10
    if (tbl_we) begin
      st_d.base[tbl_idx]  = tbl_base;
      st_d.limit[tbl_idx] = tbl_limit; // RULE_04
      st_d.attr[tbl_idx]  = tbl_attr;  // RULE_06
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign out_valid = st_q.vld;
  assign phys_addr = st_q.pa;
  assign mem_wr_en = st_q.wen;
  assign trap_size = st_q.tsz;
  assign trap_attr = st_q.tat;
  assign trap      = st_q.tsz | st_q.tat;
  assign seg_ref   = st_q.ref_f;
  assign seg_chg   = st_q.chg_f;
endmodule // sat_top

// ---- sim/sat_top_asserts.sv ----
// Port checker of the segment address translator
`timescale 1ns/1ps
module sat_chk #(parameter int NUM_SEGS = 64) (
  input wire logic                sys_clk, resetn, acc_valid, acc_wr, hist_clr,
  input wire logic                out_valid, mem_wr_en, trap, trap_size, trap_attr,
  input wire logic [23:0]         phys_addr,
  input wire logic [NUM_SEGS-1:0] seg_ref, seg_chg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ans_lat: assert property (acc_valid |=> out_valid) else $error("no answer");
  a_no_ans: assert property (!acc_valid |=> !out_valid && !trap) else $error("stray answer");
  a_trap_sum: assert property (trap == (trap_size | trap_attr)) else $error("trap mix");
  a_wr_block: assert property (trap |-> !mem_wr_en) else $error("write passed");
  a_wr_cause: assert property (mem_wr_en |-> $past(acc_wr) && out_valid) else $error("bad write");
  a_addr_hold: assert property (!acc_valid |=> $stable(phys_addr)) else $error("addr moved");
  a_chg_ref: assert property ((seg_chg & ~seg_ref) == '0) else $error("chg no ref");
  a_hist_keep: assert property (!acc_valid && !hist_clr |=> $stable(seg_ref)) else $error("ref moved");
endmodule // sat_chk
bind sat_top sat_chk #(.NUM_SEGS(NUM_SEGS)) u_chk (.*);

// ---- sim/sat_master.sv ----
// Bus master model issuing logical accesses
`timescale 1ns/1ps
module sat_master (
  input wire logic    sys_clk,
  output logic        acc_valid, acc_wr, acc_fetch, acc_sys, acc_dma,
  output logic [6:0]  acc_seg,
  output logic [15:0] acc_ofs
);
  initial {acc_valid, acc_wr, acc_fetch, acc_sys, acc_dma, acc_seg, acc_ofs} = '0;
  task automatic put(input logic [6:0] s, input logic [15:0] o, input logic [3:0] k);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_seg <= s;
    acc_ofs <= o;
    {acc_wr, acc_fetch, acc_sys, acc_dma} <= k;
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    acc_seg <= ~s;
    acc_ofs <= ~o;
  endtask
endmodule // sat_master

// ---- sim/sat_top_tb.sv ----
// Testbench of the segment address translator
`timescale 1ns/1ps
module sat_top_tb;
  logic sys_clk = 1'b0, resetn = 1'b0, tbl_we = 1'b0, hist_clr = 1'b0;
  logic [5:0] tbl_idx = 6'h00;
  sat_pkg::sat_base_t tbl_base = 24'h000000;
  sat_pkg::sat_limit_t tbl_limit = 8'h00;
  sat_pkg::sat_attr_t tbl_attr = 5'h00;
  logic acc_valid, acc_wr, acc_fetch, acc_sys, acc_dma, out_valid, mem_wr_en, trap, trap_size, trap_attr;
  logic [6:0] acc_seg;
  logic [15:0] acc_ofs;
  sat_pkg::sat_base_t phys_addr;
  logic [63:0] seg_ref, seg_chg;
  int err_total = 0, num_checks = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  sat_master m (.*);
  sat_top uut (.*);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic prog(input logic [5:0] i, input logic [23:0] b, input logic [7:0] l, input logic [4:0] a);
    @(posedge sys_clk);
    {tbl_we, tbl_idx, tbl_base, tbl_limit, tbl_attr} <= {1'b1, i, b, l, a};
    @(posedge sys_clk);
    tbl_we <= 1'b0;
  endtask
  task automatic acc(input logic [6:0] s, input logic [15:0] o, input logic [3:0] k);
    m.put(s, o, k);
    #1;
  endtask
  task automatic s_size;
    prog(6'h03, 24'h012300, 8'h01, 5'h00);
    acc(7'h43, 16'h01FF, 4'hA);
    chk({out_valid, mem_wr_en, seg_chg[3]}, 3'h7);
    chk(phys_addr, 24'h0124FF);
    acc(7'h03, 16'h0200, 4'hA);
    chk({trap, trap_size, mem_wr_en}, 3'h6);
  endtask
  task automatic s_attr;
    logic [3:0] bad [5] = '{4'hA, 4'h0, 4'h2, 4'h2, 4'h3};
    @(posedge sys_clk);
    hist_clr <= 1'b1;
    @(posedge sys_clk);
    hist_clr <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      prog(6'h05, 24'h000000, 8'hFF, 5'h01 << i);
      acc(7'h05, 16'hFFFF, bad[i]);
      chk({trap_attr, mem_wr_en, seg_ref[5]}, 3'h4);
    end
    acc(7'h05, 16'h0010, 4'h2);
    chk({trap, seg_ref[5], seg_chg[5]}, 3'h2);
  endtask
  task automatic s_hist;
    fork
      m.put(7'h05, 16'h0020, 4'h2);
      begin
        @(posedge sys_clk);
        hist_clr <= 1'b1;
        @(posedge sys_clk);
        hist_clr <= 1'b0;
      end
    join
    #1;
    chk({seg_ref[5], seg_ref[3], seg_chg[3]}, 3'h4);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk({|seg_ref, |seg_chg, out_valid}, 3'h0);
    s_size;
    s_attr;
    s_hist;
    report_and_stop;
  end
endmodule // sat_top_tb
